// File: pmsp_defines.vh
// Constants of the management serial port: frame layout, registers, timing
`ifndef PMSP_DEFINES_VH
`define PMSP_DEFINES_VH

// ==========================================================
// Clock and power-on interval
`define PMSP_CLK_MHZ          20
`define PMSP_POR_TIME_NS      10000
`define PMSP_POR_CYCLES       ((`PMSP_POR_TIME_NS * `PMSP_CLK_MHZ + 999) / 1000)
`define PMSP_POR_CNT_W        8

// ==========================================================
// Frame layout, counted in rising MDC edges
`define PMSP_IDLE_ONES        6'h20
`define PMSP_EDGE_LAST_HDR    8'h0D
`define PMSP_EDGE_TA1         8'h0E
`define PMSP_EDGE_TA2         8'h0F
`define PMSP_EDGE_FIRST_HDR   8'h02
`define PMSP_LAST_BIT         4'hF
`define PMSP_OP_READ          2'h2
`define PMSP_OP_WRITE         2'h1
`define PMSP_BURST_REGAD      5'h1F
`define PMSP_BURST_WORDS_M1   4'hA

// ==========================================================
// Register file: eleven words, indexed 0..10
`define PMSP_NUM_REGS         11
`define PMSP_IDX_CFG2         4'h7
`define PMSP_IDX_MASK         4'h9
`define PMSP_IDX_RSVD         4'hA
`define PMSP_REGAD_RSVD       5'h14
`define PMSP_RST_MASK         16'hFFC0
`define PMSP_RST_RSVD         16'h0000
`define PMSP_RST_OTHER        16'h0000

// ==========================================================
// Field positions
`define PMSP_CFG2_BURST_BIT   0
`define PMSP_MASK_SRC_HI      14
`define PMSP_MASK_SRC_LO      6
`define PMSP_MASK_DPLX_BIT    6
`define PMSP_MASK_FXLVL_HI    5
`define PMSP_MASK_FXLVL_LO    4

`endif

// File: pmsp_sync.v
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none

module pmsp_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             clock_i,
    input  wire             nrst_i,
    // Asynchronous inputs and synchronised outputs
    input  wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    genvar g;
    // ==========================================================
    // One two-stage chain per bit; only stage two leaves the module
    generate
        for (g = 0; g < WIDTH; g = g + 1) begin : gen_bit
            always @(posedge clock_i) begin
                if (!nrst_i) begin
                    meta_q[g] <= 1'b1;
                    sync_q[g] <= 1'b1;
                end else begin
                    meta_q[g] <= async_i[g];
                    sync_q[g] <= meta_q[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_q;

endmodule // pmsp_sync

`default_nettype wire

// File: pmsp_regmem.v
// Eleven-word register store with registered read data
`timescale 1ns/1ns
`default_nettype none
`include "pmsp_defines.vh"

module pmsp_regmem (
    // Clock and reset
    input  wire        clock_i,
    input  wire        nrst_i,
    // Write port
    input  wire        wr_en_i,
    input  wire [3:0]  wr_idx_i,
    input  wire [15:0] wr_data_i,
    // Read port
    input  wire [3:0]  rd_idx_i,
    output reg  [15:0] rd_data_o,
    // Words that steer the port directly
    output wire [15:0] cfg2_o,
    output wire [15:0] mask_o
);

    wire [16*`PMSP_NUM_REGS-1:0] flat;

    // Reset value of each word
    function [15:0] rst_val;
        input integer idx;
        begin
            if (idx == `PMSP_IDX_MASK)
                rst_val = `PMSP_RST_MASK;
            else if (idx == `PMSP_IDX_RSVD)
                rst_val = `PMSP_RST_RSVD;
            else
                rst_val = `PMSP_RST_OTHER;
        end
    endfunction

    genvar g;
    // ==========================================================
    // Storage words
    generate
        for (g = 0; g < `PMSP_NUM_REGS; g = g + 1) begin : gen_word
            reg [15:0] word_q;
            always @(posedge clock_i) begin
                if (!nrst_i)
                    word_q <= rst_val(g);
                else if (wr_en_i && ({28'h0000000, wr_idx_i} == g))
                    word_q <= wr_data_i;
            end
            assign flat[g*16 +: 16] = word_q;
        end
    endgenerate

    // Registered read; indexes past the end read as zero
    always @(posedge clock_i) begin
        if (!nrst_i)
            rd_data_o <= 16'h0000;
        else if (rd_idx_i < `PMSP_NUM_REGS)
            rd_data_o <= flat[rd_idx_i*16 +: 16];
        else
            rd_data_o <= 16'h0000;
    end

    assign cfg2_o = flat[`PMSP_IDX_CFG2*16 +: 16];
    assign mask_o = flat[`PMSP_IDX_MASK*16 +: 16];

endmodule // pmsp_regmem

`default_nettype wire

// File: pmsp_port.v
// Management serial port: frame engine, address strap capture, interrupt pin
//
// Functional notes
// - Idle after 32 consecutive ones on data
// - Data pin released while idle
// - Frame begins only on 0 then 1
// - Next 14 edges capture header, pin released
// - Sixteen data bits follow, in or out
// - After 32 edges stop, commit, release pin
// - New start ignored until idle seen again
// - Start, read, write, phy, reg, turnaround, data
// - Phy address mismatch abandons frame, pin released
// - Power-on interval: release pins, latch inverted straps
// - Read turnaround: device drives zero second bit
// - Burst only when configuration enable bit set
// - Burst moves eleven words over 176 edges
// - Burst order 0-5,16-20; stop after 192
// - Fiber level field drives transmit level output
// - Duplex mask bit gates duplex interrupt source
// - Reserved word resets zero, software keeps zero
// - Pending unmasked interrupt drives pin low
`timescale 1ns/1ns
`default_nettype none
`include "pmsp_defines.vh"

module pmsp_port (
    // Clock and reset
    input  wire        clock_i,
    input  wire        nrst_i,
    // Serial link
    input  wire        mdc_i,
    input  wire        mdio_i,
    output reg         mdio_o,
    output reg         mdio_oe_n_o,
    // Shared interrupt pin, also address strap bit 4
    input  wire        irq_pin_i,
    output reg         irq_out_n_o,
    output reg         irq_oe_n_o,
    // Shared LED pins, also address strap bits 3..0
    input  wire [3:0]  led_pin_i,
    output reg  [3:0]  programmable_led_n_o,
    output reg  [3:0]  led_oe_n_o,
    // Core side
    input  wire [3:0]  led_drive_n_i,
    input  wire [8:0]  irq_src_i,
    output reg  [1:0]  fiber_tx_level_o
);

    // ==========================================================
    // Frame states
    localparam ST_HUNT  = 3'h0;
    localparam ST_IDLE  = 3'h1;
    localparam ST_START = 3'h2;
    localparam ST_HDR   = 3'h3;
    localparam ST_DATA  = 3'h4;

    // Register address to store index
    function [3:0] reg_index;
        input [4:0] regad;
        begin
            if (regad < 5'h06)
                reg_index = regad[3:0];
            else
                reg_index = regad[3:0] - 4'hA;
        end
    endfunction

    // Register address names a real word
    function reg_valid;
        input [4:0] regad;
        begin
            reg_valid = (regad < 5'h06) ||
                        ((regad >= 5'h10) && (regad <= `PMSP_REGAD_RSVD));
        end
    endfunction

    // ==========================================================
    // Declarations
    wire [6:0]  pins_sync;
    wire        mdc_s;
    wire        mdio_s;
    wire [4:0]  strap_s;
    reg         mdc_d;
    wire        mdc_rise;

    reg  [2:0]  state;
    reg  [5:0]  ones_cnt;
    reg  [7:0]  fcnt;
    reg  [10:0] hdr;
    wire [11:0] hdr_now;
    wire [1:0]  op_now;
    wire [4:0]  phy_now;
    wire [4:0]  reg_now;
    wire        burst_now;
    wire        hdr_ok;
    reg         is_read;
    reg  [3:0]  bitcnt;
    reg  [3:0]  words_left;
    reg  [3:0]  idx;
    reg  [15:0] shreg;
    wire [15:0] next_sh;

    reg  [`PMSP_POR_CNT_W-1:0] por_cnt;
    reg         por_busy;
    reg  [4:0]  phy_addr;

    reg         wr_en;
    reg  [3:0]  wr_idx;
    reg  [15:0] wr_data;
    reg  [3:0]  rd_idx;
    wire [15:0] rd_data;
    wire [15:0] cfg2;
    wire [15:0] mask;
    wire        burst_access_enable;
    wire        duplex_change_irq_mask;
    wire        irq_pending;

    // ==========================================================
    // Pin synchronisers
    pmsp_sync #(
        .WIDTH (7)
    ) u_sync (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .async_i ({mdc_i, mdio_i, irq_pin_i, led_pin_i}),
        .sync_o  (pins_sync)
    );

    assign mdc_s   = pins_sync[6];
    assign mdio_s  = pins_sync[5];
    assign strap_s = pins_sync[4:0];

    // Rising MDC edge found on the synchronised clock
    always @(posedge clock_i) begin
        if (!nrst_i)
            mdc_d <= 1'b1;
        else
            mdc_d <= mdc_s;
    end

    assign mdc_rise = mdc_s & ~mdc_d;

    // ==========================================================
    // Register store
    pmsp_regmem u_regs (
        .clock_i   (clock_i),
        .nrst_i    (nrst_i),
        .wr_en_i   (wr_en),
        .wr_idx_i  (wr_idx),
        .wr_data_i (wr_data),
        .rd_idx_i  (rd_idx),
        .rd_data_o (rd_data),
        .cfg2_o    (cfg2),
        .mask_o    (mask)
    );

    assign burst_access_enable    = cfg2[`PMSP_CFG2_BURST_BIT];
    assign duplex_change_irq_mask = mask[`PMSP_MASK_DPLX_BIT];

    // ==========================================================
    // Power-on interval and strap capture
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            por_cnt  <= {`PMSP_POR_CNT_W{1'b0}};
            por_busy <= 1'b1;
            phy_addr <= 5'h00;
        end else if (por_busy) begin
            if (por_cnt == `PMSP_POR_CYCLES - 1) begin
                por_busy <= 1'b0;
                phy_addr <= ~strap_s;
            end else begin
                por_cnt <= por_cnt + 1'b1;
            end
        end
    end

    // ==========================================================
    // Header decode on the edge that completes it
    assign hdr_now   = {hdr[10:0], mdio_s};
    assign op_now    = hdr_now[11:10];
    assign phy_now   = hdr_now[9:5];
    assign reg_now   = hdr_now[4:0];
    assign burst_now = burst_access_enable && (reg_now == `PMSP_BURST_REGAD);
    assign hdr_ok    = ((op_now == `PMSP_OP_READ) || (op_now == `PMSP_OP_WRITE))
                       && (phy_now == phy_addr)
                       && (burst_now || reg_valid(reg_now));
    assign next_sh   = {shreg[14:0], mdio_s};

    // ==========================================================
    // Frame engine, advanced on each rising MDC edge
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            state       <= ST_HUNT;
            ones_cnt    <= 6'h00;
            fcnt        <= 8'h00;
            hdr         <= 11'h000;
            is_read     <= 1'b0;
            bitcnt      <= 4'h0;
            words_left  <= 4'h0;
            idx         <= 4'h0;
            shreg       <= 16'h0000;
            rd_idx      <= 4'h0;
            wr_en       <= 1'b0;
            wr_idx      <= 4'h0;
            wr_data     <= 16'h0000;
            mdio_o      <= 1'b1;
            mdio_oe_n_o <= 1'b1;
        end else begin
            wr_en <= 1'b0;
            if (por_busy) begin
                state       <= ST_HUNT;
                ones_cnt    <= 6'h00;
                mdio_oe_n_o <= 1'b1;
            end else if (mdc_rise) begin
                case (state)
                    ST_HUNT: begin
                        mdio_oe_n_o <= 1'b1;
                        if (!mdio_s)
                            ones_cnt <= 6'h00;
                        else if (ones_cnt == `PMSP_IDLE_ONES - 6'h01)
                            state <= ST_IDLE;
                        else
                            ones_cnt <= ones_cnt + 6'h01;
                    end
                    ST_IDLE: begin
                        if (!mdio_s)
                            state <= ST_START;
                    end
                    ST_START: begin
                        ones_cnt <= 6'h00;
                        if (mdio_s) begin
                            state <= ST_HDR;
                            fcnt  <= `PMSP_EDGE_FIRST_HDR;
                        end else begin
                            state <= ST_HUNT;
                        end
                    end
                    ST_HDR: begin
                        fcnt <= fcnt + 8'h01;
                        hdr  <= hdr_now[10:0];
                        if (fcnt == `PMSP_EDGE_LAST_HDR) begin
                            if (!hdr_ok) begin
                                state    <= ST_HUNT;
                                ones_cnt <= 6'h00;
                            end else begin
                                is_read    <= (op_now == `PMSP_OP_READ);
                                idx        <= burst_now ? 4'h0 : reg_index(reg_now);
                                rd_idx     <= burst_now ? 4'h0 : reg_index(reg_now);
                                words_left <= burst_now ? `PMSP_BURST_WORDS_M1 : 4'h0;
                            end
                        end
                        // Second turnaround bit driven low on reads
                        if ((fcnt == `PMSP_EDGE_TA1) && is_read) begin
                            mdio_o      <= 1'b0;
                            mdio_oe_n_o <= 1'b0;
                        end
                        if (fcnt == `PMSP_EDGE_TA2) begin
                            state  <= ST_DATA;
                            bitcnt <= 4'h0;
                            if (is_read) begin
                                shreg  <= rd_data;
                                mdio_o <= rd_data[15];
                                rd_idx <= idx + 4'h1;
                            end
                        end
                    end
                    ST_DATA: begin
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == `PMSP_LAST_BIT) begin
                            if (!is_read) begin
                                wr_en   <= 1'b1;
                                wr_idx  <= idx;
                                wr_data <= next_sh;
                            end
                            if (words_left == 4'h0) begin
                                state       <= ST_HUNT;
                                ones_cnt    <= 6'h00;
                                mdio_oe_n_o <= 1'b1;
                            end else begin
                                words_left <= words_left - 4'h1;
                                idx        <= idx + 4'h1;
                                rd_idx     <= idx + 4'h2;
                                if (is_read) begin
                                    shreg  <= rd_data;
                                    mdio_o <= rd_data[15];
                                end
                            end
                        end else begin
                            shreg  <= next_sh;
                            mdio_o <= shreg[14];
                        end
                    end
                    default: begin
                        state       <= ST_HUNT;
                        ones_cnt    <= 6'h00;
                        mdio_oe_n_o <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Interrupt source gating; duplex source sits at index zero
    assign irq_pending = |(irq_src_i[8:1] & ~mask[`PMSP_MASK_SRC_HI:`PMSP_MASK_SRC_LO+1])
                         | (irq_src_i[0] & ~duplex_change_irq_mask);

    // Shared pins released during power-on, then driven
    always @(posedge clock_i) begin
        if (!nrst_i) begin
            irq_out_n_o          <= 1'b1;
            irq_oe_n_o           <= 1'b1;
            programmable_led_n_o <= 4'hF;
            led_oe_n_o           <= 4'hF;
            fiber_tx_level_o     <= 2'h0;
        end else begin
            irq_oe_n_o           <= por_busy;
            led_oe_n_o           <= {4{por_busy}};
            irq_out_n_o          <= ~irq_pending;
            programmable_led_n_o <= led_drive_n_i;
            fiber_tx_level_o     <= mask[`PMSP_MASK_FXLVL_HI:`PMSP_MASK_FXLVL_LO];
        end
    end

endmodule // pmsp_port

`default_nettype wire

// File: pmsp_ctrl_model.sv
// Station management controller model driving the link clock and data pin
`timescale 1ns/1ns
`default_nettype none

module pmsp_ctrl_model (
    // Link pins
    output logic      mdc_o,
    output logic      drive_o,
    output logic      dat_o,
    input  wire logic mdio_i
);
    // Clock stands low and data is released outside frames
    initial begin
        mdc_o   = 1'b0;
        drive_o = 1'b0;
        dat_o   = 1'b1;
    end

    // One bit: change data after the falling edge, sample just before the rise
    task automatic bit_x(input logic drv, input logic b, output logic smp);
        mdc_o   = 1'b0;
        drive_o = drv;
        dat_o   = b;
        #200;
        smp   = mdio_i;
        mdc_o = 1'b1;
        #200;
    endtask

    // Optional idle, sixteen header bits, then nw words most significant first
    task automatic frame(input logic idl, input logic [1:0] st, input logic [1:0] op,
                         input logic [4:0] phy, input logic [4:0] ra, input int nw,
                         input logic [175:0] wd, output logic [175:0] rd, output logic ta);
        logic        rdop;
        logic        s;
        logic [15:0] hdr;
        rd   = '1;
        rdop = (op == 2'b10);
        hdr  = {st, op, phy, ra, 2'b10};
        if (idl)
            for (int i = 0; i < 32; i++) bit_x(1'b1, 1'b1, s);
        for (int i = 15; i >= 0; i--) bit_x(!(rdop && i < 2), hdr[i], s);
        ta = s;
        for (int i = 0; i < 16 * nw; i++) begin
            bit_x(!rdop, wd[175-i], s);
            rd[175-i] = s;
        end
        mdc_o   = 1'b0;
        drive_o = 1'b0;
        // Let one low half period pass so a following frame never re-drives in the same step
        #200;
    endtask
endmodule // pmsp_ctrl_model

`default_nettype wire

// File: pmsp_port_assertions.sv
// Concurrent checks on the management serial port pins
`timescale 1ns/1ns
`default_nettype none

module pmsp_port_checker (
    // Clock and reset
    input wire logic       clock_i,
    input wire logic       nrst_i,
    // Link and pins
    input wire logic       mdc_i,
    input wire logic       mdio_o,
    input wire logic       mdio_oe_n_o,
    input wire logic       irq_out_n_o,
    input wire logic       irq_oe_n_o,
    input wire logic [3:0] led_oe_n_o,
    input wire logic [3:0] programmable_led_n_o,
    // Core side
    input wire logic [3:0] led_drive_n_i,
    input wire logic [8:0] irq_src_i,
    input wire logic [1:0] fiber_tx_level_o
);
    logic [7:0] por_cnt;
    logic [3:0] since_rise;
    logic       mdc_q;

    // Cycles since reset release and since the last raw link clock rise
    always_ff @(posedge clock_i) begin
        if (!nrst_i) begin
            por_cnt    <= 8'h00;
            since_rise <= 4'hF;
            mdc_q      <= 1'b0;
        end else begin
            mdc_q      <= mdc_i;
            por_cnt    <= (por_cnt == 8'hFF) ? 8'hFF : por_cnt + 8'h01;
            since_rise <= (mdc_i && !mdc_q) ? 4'h0 : ((since_rise == 4'hF) ? 4'hF : since_rise + 4'h1);
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    // ==========================================================
    // Checks
    reset_outputs_a: assert property (disable iff (1'b0)
        !nrst_i |=> mdio_oe_n_o && irq_oe_n_o && led_oe_n_o == 4'hF && fiber_tx_level_o == 2'h0)
        else $error("pins not released in reset");
    por_hold_a: assert property (por_cnt <= 8'hC6 |-> irq_oe_n_o && led_oe_n_o == 4'hF && mdio_oe_n_o)
        else $error("pins driven inside power-on interval");
    por_end_a: assert property (por_cnt == 8'hCE |-> !irq_oe_n_o && led_oe_n_o == 4'h0)
        else $error("pins not driven after power-on interval");
    led_follow_a: assert property ($past(nrst_i) |-> programmable_led_n_o == $past(led_drive_n_i))
        else $error("led output does not follow core value");
    irq_quiet_a: assert property ($past(nrst_i) && $past(irq_src_i) == 9'h000 |-> irq_out_n_o)
        else $error("interrupt pin low without source");
    ta_zero_a: assert property ($fell(mdio_oe_n_o) |-> !mdio_o)
        else $error("turnaround bit not zero");
    drive_timing_a: assert property (!mdio_oe_n_o && $past(!mdio_oe_n_o) && $changed(mdio_o)
        |-> since_rise >= 4'h2 && since_rise <= 4'h6)
        else $error("read data changed away from clock rise");
    release_timing_a: assert property ($rose(mdio_oe_n_o) |-> since_rise >= 4'h2 && since_rise <= 4'h6)
        else $error("data pin released away from clock rise");
endmodule // pmsp_port_checker

`default_nettype wire

// File: pmsp_port_test.sv
// Testbench of the management serial port with a controller model
`timescale 1ns/1ns
`default_nettype none

module pmsp_port_test;
    localparam logic [4:0] PHY = 5'h15;
    logic         clock_i;
    logic         nrst_i;
    logic [3:0]   led_drive_n_i;
    logic [8:0]   irq_src_i;
    logic [4:0]   strap;
    wire          mdc, mdio_o, mdio_oe_n_o, ctl_drive, ctl_dat, mdio_line;
    wire          irq_out_n_o, irq_oe_n_o, irq_pin;
    wire  [3:0]   programmable_led_n_o, led_oe_n_o, led_pin;
    wire  [1:0]   fiber_tx_level_o;
    int           n_fail, comparisons, cycles;
    logic [175:0] rd, bw;
    logic         ta;
    logic [13:0]  bad [7];

    // Pin levels: the driving party wins, otherwise pull-up or strap level
    assign mdio_line = !mdio_oe_n_o ? mdio_o : (ctl_drive ? ctl_dat : 1'b1);
    assign irq_pin   = irq_oe_n_o ? strap[4] : irq_out_n_o;
    assign led_pin   = (led_oe_n_o & strap[3:0]) | (~led_oe_n_o & programmable_led_n_o);

    pmsp_port pmsp_port_i (.clock_i(clock_i), .nrst_i(nrst_i), .mdc_i(mdc), .mdio_i(mdio_line),
        .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .irq_pin_i(irq_pin), .irq_out_n_o(irq_out_n_o),
        .irq_oe_n_o(irq_oe_n_o), .led_pin_i(led_pin), .programmable_led_n_o(programmable_led_n_o),
        .led_oe_n_o(led_oe_n_o), .led_drive_n_i(led_drive_n_i), .irq_src_i(irq_src_i),
        .fiber_tx_level_o(fiber_tx_level_o));
    pmsp_ctrl_model pmsp_ctrl_model_i (.mdc_o(mdc), .drive_o(ctl_drive), .dat_o(ctl_dat), .mdio_i(mdio_line));

    // Clock
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    // Hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            stop_test();
        end
    end

    // ==========================================================
    // Tasks
    task automatic check(input string what, input logic [175:0] seen, input logic [175:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (n_fail == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    task automatic wr(input logic [4:0] ra, input logic [15:0] d);
        pmsp_ctrl_model_i.frame(1'b1, 2'b01, 2'b01, PHY, ra, 1, {d, 160'h0}, rd, ta);
        wait_clk(4);
    endtask

    task automatic rdchk(input string what, input logic [4:0] ra, input logic [15:0] exp);
        pmsp_ctrl_model_i.frame(1'b1, 2'b01, 2'b10, PHY, ra, 1, '1, rd, ta);
        check(what, 176'(rd[175:160]), 176'(exp));
        check("turnaround", 176'(ta), 176'h0);
    endtask

    // ==========================================================
    // Sequence
    initial begin
        nrst_i = 1'b0;
        led_drive_n_i = 4'h5;
        irq_src_i = 9'h000;
        strap = ~PHY;
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        bad = '{{2'b00, 2'b10, PHY, 5'h00}, {2'b01, 2'b11, PHY, 5'h00}, {2'b01, 2'b00, PHY, 5'h00},
                {2'b01, 2'b10, 5'h0A, 5'h00}, {2'b01, 2'b01, 5'h0A, 5'h00}, {2'b01, 2'b10, PHY, 5'h1F},
                {2'b01, 2'b10, PHY, 5'h06}};
        bw = {16'h0101, 16'h1102, 16'h2203, 16'h3304, 16'h4405, 16'h5506,
              16'h6607, 16'h7701, 16'h8808, 16'h00F0, 16'h0000};
        wait_clk(16);
        nrst_i = 1'b1;
        wait_clk(220);
        check("led", 176'(programmable_led_n_o), 176'h5);
        pmsp_ctrl_model_i.frame(1'b0, 2'b01, 2'b10, PHY, 5'h14, 1, '1, rd, ta);
        check("read without idle", 176'(rd[175:160]), 176'hFFFF);
        rdchk("reserved reset", 5'h14, 16'h0000);
        rdchk("mask reset", 5'h13, 16'hFFC0);
        check("fiber default", 176'(fiber_tx_level_o), 176'h0);
        for (int i = 0; i < 4; i++) begin
            wr(5'h13, 16'(i) << 4);
            check("fiber level", 176'(fiber_tx_level_o), 176'(i));
        end
        irq_src_i = 9'h001;
        wait_clk(4);
        check("duplex unmasked", 176'(irq_out_n_o), 176'h0);
        wr(5'h13, 16'h0040);
        check("duplex masked", 176'(irq_out_n_o), 176'h1);
        irq_src_i = 9'h002;
        wait_clk(4);
        check("other source", 176'(irq_out_n_o), 176'h0);
        irq_src_i = 9'h000;
        wr(5'h00, 16'h1234);
        pmsp_ctrl_model_i.frame(1'b0, 2'b01, 2'b01, PHY, 5'h00, 1, {16'hBEEF, 160'h0}, rd, ta);
        rdchk("reg 0", 5'h00, 16'h1234);
        for (int i = 0; i < 7; i++) begin
            pmsp_ctrl_model_i.frame(1'b1, bad[i][13:12], bad[i][11:10], bad[i][9:5], bad[i][4:0], 1, '1, rd, ta);
            check("aborted frame", 176'(rd[175:160]), 176'hFFFF);
        end
        rdchk("reg 0 kept", 5'h00, 16'h1234);
        wr(5'h11, 16'h0001);
        pmsp_ctrl_model_i.frame(1'b1, 2'b01, 2'b10, PHY, 5'h1F, 11, '1, rd, ta);
        check("burst read", rd, {16'h1234, 96'h0, 16'h0001, 16'h0000, 16'h0040, 16'h0000});
        pmsp_ctrl_model_i.frame(1'b1, 2'b01, 2'b01, PHY, 5'h1F, 11, bw, rd, ta);
        wait_clk(4);
        check("burst fiber", 176'(fiber_tx_level_o), 176'h3);
        rdchk("reg 17", 5'h11, 16'h7701);
        pmsp_ctrl_model_i.frame(1'b1, 2'b01, 2'b10, PHY, 5'h1F, 11, '1, rd, ta);
        check("burst readback", rd, bw);
        stop_test();
    end
endmodule // pmsp_port_test

bind pmsp_port pmsp_port_checker pmsp_port_checker_i (.clock_i(clock_i), .nrst_i(nrst_i), .mdc_i(mdc_i),
    .mdio_o(mdio_o), .mdio_oe_n_o(mdio_oe_n_o), .irq_out_n_o(irq_out_n_o), .irq_oe_n_o(irq_oe_n_o),
    .led_oe_n_o(led_oe_n_o), .programmable_led_n_o(programmable_led_n_o), .led_drive_n_i(led_drive_n_i),
    .irq_src_i(irq_src_i), .fiber_tx_level_o(fiber_tx_level_o));

`default_nettype wire
